// ---- dcw_pkg.sv ----
package dcw_pkg;
   // ------------------------------------------------------------
   // Control word field positions and reset values
   // ------------------------------------------------------------
   localparam int BRIGHT_LSB = 0;
   localparam int FLASH_EN_BIT = 3;
   localparam int BLINK_EN_BIT = 4;
   localparam int TEST_PASS_BIT = 5;
   localparam int TEST_START_BIT = 6;
   localparam int CLEAR_BIT = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_PASS_MASK = 8'h20;
   localparam logic [2:0] BRIGHT_BLANK = 3'h7;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam logic [7:0] GLYPH_ADDR_ONES = 8'hFF;
   // ------------------------------------------------------------
   // Address decode of the control word
   // ------------------------------------------------------------
   localparam logic [4:0] CTRL_ADDR = 5'h10;
   localparam logic [4:0] CTRL_ADDR_MASK = 5'h18;
   // ------------------------------------------------------------
   // Timing counts in display clock periods, then character count and self test constants
   // ------------------------------------------------------------
   localparam int SELFTEST_CYCLES = 262144;
   localparam int CLEAR_CYCLES = 3;
   localparam int RESET_SEQ_CYCLES = 3;
   localparam int FLASH_DIVIDE = 28672;
   localparam int PATTERN_CYCLES = SELFTEST_CYCLES / 2;
   localparam int CHAR_COUNT = 8;
   localparam logic [7:0] ROM_CHECKSUM = 8'h00;
   localparam logic [7:0] CHECKER_PATTERN = 8'h55;
   // Brightness in percent for codes 000 to 111.
   function automatic logic [6:0] bright_percent(input logic [2:0] code);
      unique case (code)
         3'h0: bright_percent = 7'd100;
         3'h1: bright_percent = 7'd80;
         3'h2: bright_percent = 7'd53;
         3'h3: bright_percent = 7'd40;
         3'h4: bright_percent = 7'd27;
         3'h5: bright_percent = 7'd20;
         3'h6: bright_percent = 7'd13;
         3'h7: bright_percent = 7'd0;
      endcase
   endfunction
endpackage

// ---- dcw_if.sv ----
interface dcw_if;
   import dcw_pkg::*;
   logic reset_n;
   logic chip_en_n;
   logic write_n;
   logic read_n;
   logic attribute_ram_select;
   logic [4:0] addr;
   logic [7:0] data_host;
   logic data_host_oe;
   logic [7:0] data_dev;
   logic data_dev_oe;
   wire [7:0] data_bus = data_dev_oe ? data_dev :
      (data_host_oe ? data_host : 8'h00);
   modport device (input reset_n, input chip_en_n, input write_n,
      input read_n, input attribute_ram_select, input addr,
      input data_bus, output data_dev, output data_dev_oe);
   modport host (output reset_n, output chip_en_n, output write_n,
      output read_n, output attribute_ram_select, output addr,
      output data_host, output data_host_oe, input data_bus);
endinterface

// ---- dcw_device.sv ----
module dcw_device
   import dcw_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   // Host bus
   dcw_if.device bus,
   // Display state
   output logic [6:0] brightness_o,
   output logic blank_o,
   output logic flash_phase_o,
   output logic [7:0] led_pattern_o,
   output logic busy_o,
   output logic [7:0] ctrl_o,
   output logic [7:0] glyph_addr_o
);
   typedef enum logic [1:0] {ST_RESET, ST_IDLE, ST_TEST, ST_CLEAR} dcw_st_t;
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] ce_sync;
      logic [1:0] wr_sync;
      logic [1:0] rd_sync;
      logic [1:0] fl_sync;
      logic [4:0] a_meta;
      logic [4:0] a_sync;
      logic [7:0] d_meta;
      logic [7:0] d_sync;
      logic wr_prev;
      dcw_st_t st;
      logic [17:0] cnt;
      logic [14:0] div;
      logic flash;
      logic [7:0] ctrl;
      logic [7:0] glyph_addr;
      logic [7:0] chk;
      logic [CHAR_COUNT-1:0][7:0] char_ram;
      logic [CHAR_COUNT-1:0] flash_ram;
      logic [7:0] dout;
      logic dout_oe;
      logic [6:0] bright;
      logic blank;
      logic [7:0] leds;
      logic busy;
   } dcw_dev_t;
   dcw_dev_t r, next_r;
   logic ctrl_sel;
   logic wr_edge;
   always_comb
   begin
      next_r = r;
      next_r.rst_sync = {r.rst_sync[0], bus.reset_n};
      next_r.ce_sync = {r.ce_sync[0], bus.chip_en_n};
      next_r.wr_sync = {r.wr_sync[0], bus.write_n};
      next_r.rd_sync = {r.rd_sync[0], bus.read_n};
      next_r.fl_sync = {r.fl_sync[0], bus.attribute_ram_select};
      next_r.a_meta = bus.addr;
      next_r.a_sync = r.a_meta;
      next_r.d_meta = bus.data_bus;
      next_r.d_sync = r.d_meta;
      next_r.wr_prev = r.wr_sync[1];
      ctrl_sel = r.fl_sync[1] && ((r.a_sync & CTRL_ADDR_MASK) == CTRL_ADDR);
      wr_edge = !r.ce_sync[1] && !r.wr_sync[1] && r.wr_prev && ctrl_sel;
      // Flash and blink timebase.
      if (r.div == 15'(FLASH_DIVIDE - 1))
      begin
         next_r.div = '0;
         next_r.flash = !r.flash;
      end
      else
      begin
         next_r.div = r.div + 15'd1;
      end
      next_r.bright = bright_percent(r.ctrl[2:0]);
      next_r.blank = (r.ctrl[2:0] == BRIGHT_BLANK) ||
         (r.ctrl[BLINK_EN_BIT] && r.flash);
      next_r.leds = '0;
      for (int i = 0; i < CHAR_COUNT; i++)
      begin
         next_r.leds[i] = !(r.ctrl[FLASH_EN_BIT] && r.flash_ram[i] &&
            r.flash);
      end
      // Read path: only the control word is answered here.
      next_r.dout_oe = !r.ce_sync[1] && !r.rd_sync[1] && r.wr_sync[1] &&
         ctrl_sel && r.st == ST_IDLE;
      next_r.dout = r.ctrl;
      if (!r.rst_sync[1])
      begin
         // Held in reset; sequence restarts from zero.
         next_r.st = ST_RESET;
         next_r.cnt = '0;
         next_r.div = '0;
         next_r.flash = 1'b0;
         next_r.ctrl = CTRL_RESET;
         next_r.flash_ram = '0;
         for (int i = 0; i < CHAR_COUNT; i++)
         begin
            next_r.char_ram[i] = SPACE_CODE;
         end
      end
      else
      begin
         unique case (r.st)
            ST_RESET:
            begin
               next_r.cnt = r.cnt + 18'd1;
               if (r.cnt == 18'(RESET_SEQ_CYCLES - 1))
               begin
                  next_r.st = ST_IDLE;
                  next_r.cnt = '0;
               end
            end
            ST_IDLE:
            begin
               if (wr_edge)
               begin
                  // Bit 5 is read only and keeps its value.
                  next_r.ctrl = (r.d_sync & ~CTRL_PASS_MASK) |
                     (r.ctrl & CTRL_PASS_MASK);
                  if (r.d_sync[TEST_START_BIT])
                  begin
                     next_r.st = ST_TEST;
                     next_r.cnt = '0;
                     next_r.chk = '0;
                  end
                  else if (r.d_sync[CLEAR_BIT])
                  begin
                     next_r.st = ST_CLEAR;
                     next_r.cnt = '0;
                  end
               end
            end
            ST_TEST:
            begin
               next_r.cnt = r.cnt + 18'd1;
               // Walk decoder states and fold them into the checksum.
               next_r.chk = r.chk ^ r.cnt[7:0];
               next_r.leds = r.cnt[17] ? ~CHECKER_PATTERN :
                  CHECKER_PATTERN;
               if (r.cnt == 18'(SELFTEST_CYCLES - 1))
               begin
                  next_r.st = ST_IDLE;
                  next_r.cnt = '0;
                  next_r.ctrl = '0;
                  next_r.ctrl[TEST_PASS_BIT] =
                     (next_r.chk == ROM_CHECKSUM);
                  next_r.flash_ram = '0;
                  next_r.glyph_addr = GLYPH_ADDR_ONES;
                  for (int i = 0; i < CHAR_COUNT; i++)
                  begin
                     next_r.char_ram[i] = SPACE_CODE;
                  end
               end
            end
            ST_CLEAR:
            begin
               next_r.cnt = r.cnt + 18'd1;
               next_r.flash_ram = '0;
               for (int i = 0; i < CHAR_COUNT; i++)
               begin
                  next_r.char_ram[i] = SPACE_CODE;
               end
               if (r.cnt == 18'(CLEAR_CYCLES - 1))
               begin
                  next_r.st = ST_IDLE;
                  next_r.cnt = '0;
                  next_r.ctrl[CLEAR_BIT] = 1'b0;
               end
            end
         endcase
      end
      next_r.busy = next_r.st != ST_IDLE;
   end
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         r <= '0;
         r.rst_sync <= 2'b00;
         r.ce_sync <= 2'b11;
         r.wr_sync <= 2'b11;
         r.rd_sync <= 2'b11;
         r.wr_prev <= 1'b1;
         r.st <= ST_RESET;
         r.busy <= 1'b1;
      end
      else if (clk_en_i)
      begin
         r <= next_r;
      end
   end
   assign bus.data_dev = r.dout;
   assign bus.data_dev_oe = r.dout_oe;
   assign brightness_o = r.bright;
   assign blank_o = r.blank;
   assign flash_phase_o = r.flash;
   assign led_pattern_o = r.leds;
   assign busy_o = r.busy;
   assign ctrl_o = r.ctrl;
   assign glyph_addr_o = r.glyph_addr;
endmodule

// ---- dcw_host.sv ----
module dcw_host
   import dcw_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   // User commands
   input wire logic write_i,
   input wire logic read_i,
   input wire logic reset_i,
   input wire logic [7:0] wdata_i,
   input wire logic dev_busy_i,
   output logic ready_o,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   // Device bus
   dcw_if.host bus
);
   typedef enum logic [2:0] {H_IDLE, H_RST, H_WR, H_RD, H_WAIT} dcw_hst_t;
   typedef struct packed {
      dcw_hst_t st;
      logic [2:0] cnt;
      logic rst_n;
      logic ce_n;
      logic wr_n;
      logic rd_n;
      logic [7:0] d;
      logic d_oe;
      logic [7:0] rdata;
      logic rvalid;
      logic ready;
   } dcw_hst_s_t;
   dcw_hst_s_t r, next_r;
   always_comb
   begin
      next_r = r;
      next_r.rvalid = 1'b0;
      next_r.ready = 1'b0;
      unique case (r.st)
         H_IDLE:
         begin
            // No write or read access while the device is busy; reset_i is still accepted.
            next_r.ready = !dev_busy_i;
            if (reset_i)
            begin
               next_r.st = H_RST;
               next_r.rst_n = 1'b0;
               next_r.ce_n = 1'b1;
               next_r.ready = 1'b0;
            end
            else if (!dev_busy_i && write_i)
            begin
               next_r.st = H_WR;
               next_r.ce_n = 1'b0;
               next_r.wr_n = 1'b0;
               next_r.d = wdata_i;
               next_r.d_oe = 1'b1;
               next_r.cnt = '0;
               next_r.ready = 1'b0;
            end
            else if (!dev_busy_i && read_i)
            begin
               next_r.st = H_RD;
               next_r.ce_n = 1'b0;
               next_r.rd_n = 1'b0;
               next_r.cnt = '0;
               next_r.ready = 1'b0;
            end
         end
         H_RST:
         begin
            next_r.cnt = r.cnt + 3'd1;
            if (r.cnt == 3'd7)
            begin
               next_r.rst_n = 1'b1;
               next_r.st = H_WAIT;
               next_r.cnt = '0;
            end
         end
         H_WR, H_RD:
         begin
            next_r.cnt = r.cnt + 3'd1;
            if (r.cnt == 3'd7)
            begin
               next_r.rdata = bus.data_bus;
               next_r.rvalid = (r.st == H_RD);
               next_r.ce_n = 1'b1;
               next_r.wr_n = 1'b1;
               next_r.rd_n = 1'b1;
               next_r.d_oe = 1'b0;
               next_r.st = H_WAIT;
               next_r.cnt = '0;
            end
         end
         H_WAIT:
         begin
            next_r.cnt = r.cnt + 3'd1;
            if (r.cnt == 3'd7)
            begin
               next_r.st = H_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         r <= '0;
         r.st <= H_IDLE;
         r.rst_n <= 1'b1;
         r.ce_n <= 1'b1;
         r.wr_n <= 1'b1;
         r.rd_n <= 1'b1;
      end
      else if (clk_en_i)
      begin
         r <= next_r;
      end
   end
   assign bus.reset_n = r.rst_n;
   assign bus.chip_en_n = r.ce_n;
   assign bus.write_n = r.wr_n;
   assign bus.read_n = r.rd_n;
   assign bus.attribute_ram_select = 1'b1;
   assign bus.addr = CTRL_ADDR;
   assign bus.data_host = r.d;
   assign bus.data_host_oe = r.d_oe;
   assign ready_o = r.ready;
   assign rdata_o = r.rdata;
   assign rvalid_o = r.rvalid;
endmodule

// ---- dcw_asserts.sv ----
module dcw_asserts
   import dcw_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Interface and device state
   input wire logic reset_n,
   input wire logic data_dev_oe,
   input wire logic data_host_oe,
   input wire logic [6:0] brightness_o,
   input wire logic blank_o,
   input wire logic busy_o,
   input wire logic [7:0] ctrl_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] PCT [8] = '{7'h64, 7'h50, 7'h35, 7'h28,
      7'h1B, 7'h14, 7'h0D, 7'h00};
   logic [1:0] up;
   logic steady;
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         up <= 2'h0;
      end
      else if (up != 2'h3)
      begin
         up <= up + 2'h1;
      end
   end
   assign steady = (up == 2'h3);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_bright_decode: assert property (steady && $stable(ctrl_o) |->
      brightness_o == PCT[ctrl_o[2:0]]) else $error("brightness wrong");
   a_blank_code: assert property (steady && $stable(ctrl_o) &&
      ctrl_o[2:0] == BRIGHT_BLANK |-> blank_o) else $error("not blank");
   a_clear_self_ends: assert property ($rose(ctrl_o[7]) |->
      ##[1:6] !ctrl_o[7]) else $error("clear bit stuck");
   a_clear_keeps_rest: assert property ($fell(ctrl_o[7]) && reset_n |->
      ctrl_o[6:0] == $past(ctrl_o[6:0])) else $error("clear lost bits");
   a_pass_read_only: assert property ($rose(ctrl_o[5]) |->
      $past(ctrl_o[6])) else $error("pass bit set by write");
   a_test_end_zero: assert property ($fell(ctrl_o[6]) |->
      ctrl_o[7:6] == 2'h0 && ctrl_o[4:0] == 5'h00)
      else $error("test end state wrong");
   a_no_contend: assert property (!(data_dev_oe && data_host_oe))
      else $error("bus contention");
   a_reset_clears: assert property ($rose(reset_n) |->
      ##[0:6] (ctrl_o == 8'h00 && busy_o)) else $error("reset no clear");
   a_reset_seq_len: assert property ($rose(reset_n) |->
      ##[3:10] !busy_o) else $error("reset sequence too long");
   c_clear: cover property ($fell(ctrl_o[7]));
   c_bus_reset: cover property ($rose(reset_n));
   c_test_start: cover property ($rose(ctrl_o[6]));
endmodule

// ---- display_control_selftest_clear_reset_tb.sv ----
module display_control_selftest_clear_reset_tb
   import dcw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic write_i = 1'b0;
   logic read_i = 1'b0;
   logic reset_i = 1'b0;
   logic [7:0] wdata_i = 8'h00;
   logic ready_o, rvalid_o, blank_o, busy_o;
   logic [7:0] rdata_o, ctrl_o, d;
   logic [7:0] led_pattern_o, glyph_addr_o;
   logic flash_phase_o, f;
   logic clk_en = 1'b1;
   int k = 0;
   logic [6:0] brightness_o;
   logic [7:0] exp_q [$];
   int failures = 0;
   int n_tests = 0;
   logic [6:0] pct [8] = '{7'h64, 7'h50, 7'h35, 7'h28, 7'h1B, 7'h14,
      7'h0D, 7'h00};
   dcw_if bus_if ();
   dcw_device i_dcw_device (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .clk_en_i(clk_en), .bus(bus_if.device), .brightness_o(brightness_o),
      .blank_o(blank_o), .flash_phase_o(flash_phase_o),
      .led_pattern_o(led_pattern_o), .busy_o(busy_o), .ctrl_o(ctrl_o),
      .glyph_addr_o(glyph_addr_o));
   dcw_host i_dcw_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .clk_en_i(clk_en), .write_i(write_i), .read_i(read_i),
      .reset_i(reset_i), .wdata_i(wdata_i), .dev_busy_i(busy_o),
      .ready_o(ready_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .bus(bus_if.host));
   dcw_asserts i_dcw_asserts (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .reset_n(bus_if.reset_n), .data_dev_oe(bus_if.data_dev_oe),
      .data_host_oe(bus_if.data_host_oe), .brightness_o(brightness_o),
      .blank_o(blank_o), .busy_o(busy_o), .ctrl_o(ctrl_o));
   // ------------------------------------------------------------
   // Checking and ending
   // ------------------------------------------------------------
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Host commands
   // ------------------------------------------------------------
   task automatic wait_ready();
      int i;
      i = 0;
      @(negedge ref_clk_i);
      while (ready_o !== 1'b1 && i < 400)
      begin
         @(negedge ref_clk_i);
         i++;
      end
      if (i >= 400)
      begin
         failures++;
         $display("[FAIL] %0t host never ready", $time);
      end
   endtask
   task automatic op(input logic w, r, rs, input logic [7:0] data);
      wait_ready();
      write_i = w;
      read_i = r;
      reset_i = rs;
      wdata_i = data;
      @(negedge ref_clk_i);
      write_i = 1'b0;
      read_i = 1'b0;
      reset_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
   endtask
   task automatic rd(input logic [7:0] exp);
      exp_q.push_back(exp);
      op(1'b0, 1'b1, 1'b0, 8'h00);
   endtask
   always @(negedge ref_clk_i)
   begin
      if (rvalid_o === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk_rd(rdata_o, 8'hxx);
         else
            chk_rd(rdata_o, exp_q.pop_front());
      end
   end
   initial forever #4 ref_clk_i = ~ref_clk_i;
   initial
   begin
      repeat (80000) @(posedge ref_clk_i);
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      conclude();
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h99eb3f4c));
      repeat (4) @(negedge ref_clk_i);
      rst_i = 1'b0;
      rd(8'h00);
      for (int c = 0; c < 8; c++)
      begin
         d = {2'b00, 1'($urandom()), 1'b0, 1'($urandom()), 3'(c)};
         op(1'b1, 1'b0, 1'b0, d);
         wait_ready();
         chk_val(ctrl_o, d & 8'hDF);
         chk_val({1'b0, brightness_o}, {1'b0, pct[c]});
         chk_val({7'h00, blank_o}, {7'h00, c == 7});
         rd(d & 8'hDF);
      end
      op(1'b1, 1'b0, 1'b0, 8'h8A);
      wait_ready();
      chk_val(ctrl_o, 8'h0A);
      chk_val(glyph_addr_o, 8'h00);
      rd(8'h0A);
      op(1'b0, 1'b0, 1'b1, 8'h00);
      wait_ready();
      chk_val(ctrl_o, 8'h00);
      chk_val(glyph_addr_o, 8'h00);
      op(1'b1, 1'b0, 1'b0, 8'h41);
      repeat (20) @(negedge ref_clk_i);
      chk_val({7'h00, busy_o}, 8'h01);
      chk_val({7'h00, ctrl_o[6]}, 8'h01);
      chk_val(led_pattern_o, CHECKER_PATTERN);
      rst_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk_val(ctrl_o, 8'h00);
      rd(8'h00);
      op(1'b1, 1'b0, 1'b0, 8'h10);
      wait_ready();
      f = flash_phase_o;
      while (flash_phase_o === f)
      begin
         @(negedge ref_clk_i);
      end
      @(negedge ref_clk_i);
      chk_val({7'h00, flash_phase_o}, 8'h01);
      chk_val({7'h00, blank_o}, 8'h01);
      f = flash_phase_o;
      k = 1;
      while (flash_phase_o === f)
      begin
         @(negedge ref_clk_i);
         k++;
         if (k == 1000)
            clk_en = 1'b0;
         if (k == 1100)
            clk_en = 1'b1;
      end
      chk_cnt(k, FLASH_DIVIDE + 100);
      repeat (20) @(negedge ref_clk_i);
      conclude();
   end
endmodule
